// ==== mdss_map.svh ====
`ifndef MDSS_MAP_SVH
`define MDSS_MAP_SVH

`define MDSS_REG_CTRL        8'h00
`define MDSS_REG_STATUS      8'h04
`define MDSS_REG_SPEED       8'h08
`define MDSS_REG_POSITION    8'h0C

`define MDSS_CTRL_START      0
`define MDSS_CTRL_STOP       1
`define MDSS_CTRL_MODE_REQ   2
`define MDSS_CTRL_FAULT_CLR  3
`define MDSS_CTRL_MODE_SEL   4

`define MDSS_STAT_STATE_LSB  0
`define MDSS_STAT_MODE       4
`define MDSS_STAT_SWITCH     5
`define MDSS_STAT_LOCK_LSB   6
`define MDSS_STAT_FAULT_LSB  8

// fault input indices that only a reset can clear
`define MDSS_FLT_WRONG_HW    0
`define MDSS_FLT_MAINS       1

`define MDSS_RST_MODE_SEL    1'b0
`define MDSS_RST_DATA        32'h0000_0000

`define MDSS_CLK_MHZ         250
`define MDSS_CALC_PERIOD_US  1000
`define MDSS_PER_CLK_DIV     4
`define MDSS_PER_PRESC       2
`define MDSS_ENC_PPR         1024
`define MDSS_FULL_SCALE_RPM  4000
`define MDSS_PER_LIMIT       32767

`endif

// ==== mdss_pkg.sv ====
package mdss_pkg;

   typedef enum logic [3:0] {
      MDSS_INIT_INIT_SUBSTATE_A,
      MDSS_INIT_PRIMARY,
      MDSS_INIT_OPMODE,
      MDSS_STOP,
      MDSS_RUN_EXCITE,
      MDSS_RUN_SPIN,
      MDSS_RUN_DECAY,
      MDSS_FAULT
   } mdss_state_t;

   typedef logic signed [15:0] mdss_word_t;

endpackage

// ==== mdss_speed.sv ====
`timescale 1ns/100ps
`include "mdss_map.svh"

module mdss_speed
   import mdss_pkg::*;
#(
   parameter int CALC_CYC = 250000,
   parameter int PRESC    = `MDSS_PER_PRESC,
   parameter int ENC_PPR  = `MDSS_ENC_PPR,
   parameter int QRELOAD  = 4 * ENC_PPR - 1
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // encoder pins
   input  wire logic       enc_a_i,
   input  wire logic       enc_b_i,
   // results
   output mdss_word_t      speed_o,
   output logic            speed_valid_o,
   output mdss_word_t      position_o
);
   localparam int PDIV  = `MDSS_PER_CLK_DIV * PRESC;
   localparam int TBW   = $clog2(CALC_CYC);
   localparam int PW    = $clog2(PDIV) + 1;
   localparam longint FPER = longint'(`MDSS_CLK_MHZ) * 1000000 / PDIV;
   localparam longint KSC = longint'(`MDSS_PER_LIMIT) * 60 * FPER /
      (4 * longint'(ENC_PPR) * `MDSS_FULL_SCALE_RPM);

   initial begin
      if (longint'(CALC_CYC) / PDIV >= `MDSS_PER_LIMIT || PRESC < 1 ||
          KSC >= 64'h0000_0000_FFFF_FFFF || QRELOAD < 1)
         $error("mdss_speed: period count overflows or bad parameters");
   end

   typedef struct packed {
      logic [1:0]       a_sync;
      logic [1:0]       b_sync;
      logic             a_prev;
      logic             b_prev;
      mdss_word_t       pos;
      logic [15:0]      quad;
      mdss_word_t       pcnt;
      logic [15:0]      tcnt;
      logic [PW-1:0]    pre;
      logic [TBW-1:0]   tb;
      logic             arm;
      mdss_word_t       cap_p;
      logic [15:0]      cap_t;
      mdss_word_t       prev_p;
      logic [15:0]      prev_t;
      logic             busy;
      logic [5:0]       dcnt;
      logic [47:0]      num;
      logic [15:0]      den;
      logic [16:0]      rem;
      logic             neg;
      mdss_word_t       speed;
      logic             valid;
   } mdss_spd_t;

   mdss_spd_t s_q, s_d;

   always_comb begin
      logic          a_s;
      logic          b_s;
      logic          ea;
      logic          step;
      logic          up;
      mdss_word_t    dn;
      logic [15:0]   dt;
      logic [16:0]   r;
      a_s  = s_q.a_sync[1];
      b_s  = s_q.b_sync[1];
      ea   = a_s ^ s_q.a_prev;
      step = ea ^ (b_s ^ s_q.b_prev);
      up   = a_s ^ s_q.b_prev;
      dn   = s_q.cap_p - s_q.prev_p;
      dt   = s_q.cap_t - s_q.prev_t;
      r    = {s_q.rem[15:0], s_q.num[47]};
      s_d  = s_q;
      s_d.valid  = 1'b0;
      s_d.a_sync = {s_q.a_sync[0], enc_a_i};
      s_d.b_sync = {s_q.b_sync[0], enc_b_i};
      s_d.a_prev = a_s;
      s_d.b_prev = b_s;
      if (step) begin
         s_d.pos  = up ? s_q.pos + 16'sd1 : s_q.pos - 16'sd1;
         s_d.pcnt = up ? s_q.pcnt + 16'sd1 : s_q.pcnt - 16'sd1;
         s_d.quad = (s_q.quad == 16'h0000) ? 16'(QRELOAD)
                                           : s_q.quad - 16'h0001;
      end
      if (s_q.pre == PW'(PDIV - 1)) begin
         s_d.pre  = '0;
         s_d.tcnt = s_q.tcnt + 16'h0001;
      end else begin
         s_d.pre  = s_q.pre + PW'(1);
      end
      if (ea && s_q.arm) begin
         s_d.cap_p = s_q.pcnt;
         s_d.cap_t = s_q.tcnt;
         s_d.arm   = 1'b0;
      end
      if (s_q.tb == TBW'(CALC_CYC - 1)) begin
         s_d.tb     = '0;
         s_d.prev_p = s_q.cap_p;
         s_d.prev_t = s_q.cap_t;
         s_d.arm    = 1'b1;
         s_d.neg    = dn[15];
         s_d.num    = 48'(dn[15] ? -32'(dn) : 32'(dn)) * 48'(KSC);
         s_d.den    = dt;
         s_d.rem    = '0;
         s_d.dcnt   = '0;
         if (dt == 16'h0000 || dn == 16'sd0) begin
            s_d.speed = '0;
            s_d.valid = 1'b1;
         end else begin
            s_d.busy = 1'b1;
         end
      end else begin
         s_d.tb = s_q.tb + TBW'(1);
      end
      if (s_q.busy) begin
         // restoring divide, one quotient bit per clock
         s_d.num = {s_q.num[46:0], r >= {1'b0, s_q.den}};
         s_d.rem = (r >= {1'b0, s_q.den}) ? r - {1'b0, s_q.den} : r;
         s_d.dcnt = s_q.dcnt + 6'h01;
         if (s_q.dcnt == 6'h2F) begin
            s_d.busy  = 1'b0;
            s_d.valid = 1'b1;
            if (s_d.num > 48'h00_0000_7FFF)
               s_d.speed = s_q.neg ? -16'sh7FFF : 16'sh7FFF;
            else
               s_d.speed = s_q.neg ? -s_d.num[15:0] : s_d.num[15:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign speed_o       = s_q.speed;
   assign speed_valid_o = s_q.valid;
   assign position_o    = s_q.pos;

endmodule // mdss_speed

// ==== mdss_top.sv ====
// Summary of operation
// - After reset enter initialization; drive disabled, no motor start there.
// - Init has three substates; init_substate_a taken once per entry selects next.
// - Primary init after reset or fault: sensing correction, mains check.
// - Operating-mode substate latches mode; leaves to stop only at switch stop.
// - Any fault in init, stop or run goes straight to fault.
// - Stop: drive and pads off, disabled fast loop on each end of scan.
// - Mode change request in stop returns to initialization unless a fault wins.
// - Stop with no fault and accepted start enters run.
// - Run: drive and pads on, enabled fast loop on each end of scan.
// - Excitation until nominal flux to spinning; early stop to flux decay.
// - Spinning follows speed command; accepted stop moves to flux decay.
// - Flux decay forces zero speed, then de-excites, then enters stop.
// - Fault: drive off; vanished fault, clear command, switch stop go init.
// - Wrong hardware and mains faults clear only by reset.
// - Position counter steps up or down on every encoder edge.
// - Quadrature channel counts toward zero and reloads at zero.
// - Pulse counter counts decoded pulses; period counter counts clock by eight.
// - Time base triggers speed calculation once per millisecond.
// - Each period: differences, store, arm; next phase A edge captures.
// - Speed is constant times pulse difference over clock difference.
// - Period count per calculation stays below the signed 16-bit limit.
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`include "mdss_map.svh"

module mdss_top
   import mdss_pkg::*;
#(
   parameter int FAULT_W  = 5,
   parameter int CALC_CYC = `MDSS_CLK_MHZ * `MDSS_CALC_PERIOD_US,
   parameter int PRESC    = `MDSS_PER_PRESC,
   parameter int ENC_PPR  = `MDSS_ENC_PPR
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // wishbone slave
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [31:0]        wb_dat_i,
   input  wire logic [3:0]         wb_sel_i,
   output logic [31:0]             wb_dat_o,
   output logic                    wb_ack_o,
   // pins
   input  wire logic               run_sw_i,
   input  wire logic               enc_a_i,
   input  wire logic               enc_b_i,
   // drive status inputs
   input  wire logic [FAULT_W-1:0] fault_i,
   input  wire logic               sense_corr_done_i,
   input  wire logic               mains_done_i,
   input  wire logic               mains_ok_i,
   input  wire logic               flux_nominal_i,
   input  wire logic               zero_speed_i,
   input  wire logic               deexcited_i,
   input  wire logic               eos_i,
   // drive control outputs
   output logic                    drive_en_o,
   output logic                    pwm_pad_en_o,
   output logic                    fast_loop_on_handler_o,
   output logic                    fast_loop_off_handler_o,
   output logic                    sense_corr_start_o,
   output logic                    mains_detect_start_o,
   output logic                    excite_en_o,
   output logic                    speed_cmd_en_o,
   output logic                    speed_zero_o,
   output logic                    deexcite_o,
   output logic                    go_rotate_flag_o,
   output logic                    go_flux_decay_flag_o,
   output logic                    remote_host_mode_o,
   // speed results
   output mdss_word_t              speed_o,
   output logic                    speed_valid_o,
   output mdss_word_t              position_o
);

   initial begin
      if (FAULT_W < 2 || FAULT_W > 24)
         $error("mdss_top: FAULT_W must be 2 to 24");
   end

   typedef struct packed {
      logic [1:0]    sw_sync;
      mdss_state_t   st;
      logic          prim;
      logic          prim_run;
      logic          mains_run;
      logic          mode;
      logic          mode_sel;
      logic [1:0]    lock;
      logic          decay_ph;
      logic          sc_start;
      logic          md_start;
      logic          ack;
      logic [31:0]   rdat;
   } mdss_sup_t;

   mdss_sup_t  q, d;
   mdss_word_t spd;
   mdss_word_t pos;
   logic       spd_v;

   mdss_speed #(
      .CALC_CYC (CALC_CYC),
      .PRESC    (PRESC),
      .ENC_PPR  (ENC_PPR),
      .QRELOAD  (4 * ENC_PPR - 1)
   ) u_speed (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .enc_a_i       (enc_a_i),
      .enc_b_i       (enc_b_i),
      .speed_o       (spd),
      .speed_valid_o (spd_v),
      .position_o    (pos)
   );

   always_comb begin
      logic       sw_run;
      logic       wr;
      logic       start_p;
      logic       stop_p;
      logic       modereq_p;
      logic       fclr_p;
      logic       start_cmd;
      logic       stop_cmd;
      logic       mains_bad;
      logic       any_fault;
      logic [1:0] lock_n;
      logic [31:0] rd;
      sw_run    = q.sw_sync[1];
      wr        = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack &&
                  wb_adr_i == `MDSS_REG_CTRL && wb_sel_i[0];
      start_p   = wr && wb_dat_i[`MDSS_CTRL_START];
      stop_p    = wr && wb_dat_i[`MDSS_CTRL_STOP];
      modereq_p = wr && wb_dat_i[`MDSS_CTRL_MODE_REQ];
      fclr_p    = wr && wb_dat_i[`MDSS_CTRL_FAULT_CLR];
      start_cmd = q.mode ? start_p : sw_run;
      stop_cmd  = !sw_run || stop_p;
      mains_bad = q.st == MDSS_INIT_PRIMARY && q.mains_run &&
                  mains_done_i && !mains_ok_i;
      // sticky, only reset clears these
      lock_n    = q.lock | {fault_i[`MDSS_FLT_MAINS] || mains_bad,
                            fault_i[`MDSS_FLT_WRONG_HW]};
      any_fault = |fault_i || |lock_n;
      d          = q;
      d.sw_sync  = {q.sw_sync[0], run_sw_i};
      d.lock     = lock_n;
      d.sc_start = 1'b0;
      d.md_start = 1'b0;
      if (wr)
         d.mode_sel = wb_dat_i[`MDSS_CTRL_MODE_SEL];

      unique case (q.st)
         MDSS_INIT_INIT_SUBSTATE_A: begin
            d.prim = 1'b0;
            if (q.prim) begin
               d.st        = MDSS_INIT_PRIMARY;
               d.sc_start  = 1'b1;
               d.prim_run  = 1'b1;
               d.mains_run = 1'b0;
            end else begin
               d.st = MDSS_INIT_OPMODE;
            end
         end
         MDSS_INIT_PRIMARY: begin
            if (q.prim_run && sense_corr_done_i) begin
               d.prim_run  = 1'b0;
               d.mains_run = 1'b1;
               d.md_start  = 1'b1;
            end
            if (q.mains_run && mains_done_i && mains_ok_i) begin
               d.mains_run = 1'b0;
               d.st        = MDSS_INIT_OPMODE;
            end
         end
         MDSS_INIT_OPMODE: begin
            d.mode = q.mode_sel;
            if (!sw_run)
               d.st = MDSS_STOP;
         end
         MDSS_STOP: begin
            if (modereq_p || q.mode_sel != q.mode)
               d.st = MDSS_INIT_INIT_SUBSTATE_A;
            else if (start_cmd)
               d.st = MDSS_RUN_EXCITE;
         end
         MDSS_RUN_EXCITE: begin
            if (stop_cmd) begin
               d.st       = MDSS_RUN_DECAY;
               d.decay_ph = 1'b0;
            end else if (flux_nominal_i) begin
               d.st = MDSS_RUN_SPIN;
            end
         end
         MDSS_RUN_SPIN: begin
            if (stop_cmd) begin
               d.st       = MDSS_RUN_DECAY;
               d.decay_ph = 1'b0;
            end
         end
         MDSS_RUN_DECAY: begin
            if (!q.decay_ph && zero_speed_i)
               d.decay_ph = 1'b1;
            if (q.decay_ph && deexcited_i)
               d.st = MDSS_STOP;
         end
         MDSS_FAULT: begin
            if (!any_fault && fclr_p && !sw_run) begin
               d.st   = MDSS_INIT_INIT_SUBSTATE_A;
               d.prim = 1'b1;
            end
         end
      endcase

      if (q.st != MDSS_FAULT && any_fault) begin
         d.st        = MDSS_FAULT;
         d.prim_run  = 1'b0;
         d.mains_run = 1'b0;
      end

      rd = `MDSS_RST_DATA;
      unique case (wb_adr_i)
         `MDSS_REG_CTRL:
            rd[`MDSS_CTRL_MODE_SEL] = q.mode_sel;
         `MDSS_REG_STATUS: begin
            rd[`MDSS_STAT_STATE_LSB +: 4] = q.st;
            rd[`MDSS_STAT_MODE]           = q.mode;
            rd[`MDSS_STAT_SWITCH]         = sw_run;
            rd[`MDSS_STAT_LOCK_LSB +: 2]  = q.lock;
            rd[`MDSS_STAT_FAULT_LSB +: FAULT_W] = fault_i;
         end
         `MDSS_REG_SPEED:
            rd[15:0] = spd;
         `MDSS_REG_POSITION:
            rd[15:0] = pos;
         default:
            rd = `MDSS_RST_DATA;
      endcase
      d.ack  = wb_cyc_i && wb_stb_i && !q.ack;
      d.rdat = (wb_cyc_i && wb_stb_i && !q.ack && !wb_we_i) ? rd : q.rdat;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q          <= '0;
         q.st       <= MDSS_INIT_INIT_SUBSTATE_A;
         q.prim     <= 1'b1;
         q.mode_sel <= `MDSS_RST_MODE_SEL;
      end else begin
         q <= d;
      end
   end

   logic running;
   assign running = q.st == MDSS_RUN_EXCITE || q.st == MDSS_RUN_SPIN ||
                    q.st == MDSS_RUN_DECAY;

   assign drive_en_o              = running;
   assign pwm_pad_en_o            = running;
   assign fast_loop_on_handler_o  = eos_i && running;
   assign fast_loop_off_handler_o = eos_i && q.st == MDSS_STOP;
   assign sense_corr_start_o      = q.sc_start;
   assign mains_detect_start_o    = q.md_start;
   assign excite_en_o             = running;
   assign speed_cmd_en_o          = q.st == MDSS_RUN_SPIN;
   assign speed_zero_o            = q.st == MDSS_RUN_DECAY;
   assign deexcite_o              = q.st == MDSS_RUN_DECAY && q.decay_ph;
   assign go_rotate_flag_o        = q.st == MDSS_RUN_SPIN;
   assign go_flux_decay_flag_o    = q.st == MDSS_RUN_DECAY;
   assign remote_host_mode_o      = q.mode;
   assign speed_o                 = spd;
   assign speed_valid_o           = spd_v;
   assign position_o              = pos;
   assign wb_dat_o                = q.rdat;
   assign wb_ack_o                = q.ack;

endmodule // mdss_top

// ==== mdss_chk.sv ====
`timescale 1ns/100ps
module mdss_chk #(
   parameter int FAULT_W = 5
) (
   // clock and reset
   input wire logic               clk_i,
   input wire logic               rst_i,
   // bus
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_ack_o,
   // drive status
   input wire logic [FAULT_W-1:0] fault_i,
   input wire logic               eos_i,
   input wire logic               flux_nominal_i,
   input wire logic               deexcited_i,
   // drive control
   input wire logic               drive_en_o,
   input wire logic               pwm_pad_en_o,
   input wire logic               excite_en_o,
   input wire logic               fast_loop_on_handler_o,
   input wire logic               fast_loop_off_handler_o,
   input wire logic               sense_corr_start_o,
   input wire logic               speed_zero_o,
   input wire logic               go_rotate_flag_o,
   input wire logic               go_flux_decay_flag_o,
   input wire logic               speed_valid_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ACK_REQ: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("long ack");
   AST_INIT_OFF: assert property (
      $fell(rst_i) |-> !drive_en_o ##1 !drive_en_o)
      else $error("drive on in init");
   AST_PRIMARY: assert property (
      $fell(rst_i) |-> ##[0:2] sense_corr_start_o)
      else $error("no primary init");
   AST_FAULT_OFF: assert property (
      fault_i != '0 |=> !drive_en_o && !pwm_pad_en_o)
      else $error("drive on after a fault");
   AST_OFF_LOOP: assert property (
      fast_loop_off_handler_o |-> eos_i && !drive_en_o && !pwm_pad_en_o)
      else $error("off loop outside stop");
   AST_ON_LOOP: assert property (
      eos_i && drive_en_o |-> fast_loop_on_handler_o
         && !fast_loop_off_handler_o)
      else $error("on loop missing");
   AST_RUN_PADS: assert property (
      drive_en_o |-> pwm_pad_en_o && excite_en_o)
      else $error("pads off in run");
   AST_SPIN_ENTRY: assert property (
      $rose(go_rotate_flag_o) |-> $past(flux_nominal_i)
         && $past(excite_en_o))
      else $error("spin without flux");
   AST_DECAY_ZERO: assert property (
      go_flux_decay_flag_o |-> speed_zero_o && !go_rotate_flag_o)
      else $error("speed not zeroed");
   AST_DECAY_EXIT: assert property (
      $fell(go_flux_decay_flag_o) |-> $past(deexcited_i)
         || $past(fault_i) != '0)
      else $error("decay left early");
   AST_VALID_PULSE: assert property (
      speed_valid_o |=> !speed_valid_o [*8])
      else $error("valid too close");
endmodule // mdss_chk

bind mdss_top mdss_chk #(.FAULT_W(FAULT_W)) mdss_chk_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fault_i(fault_i),
   .eos_i(eos_i), .flux_nominal_i(flux_nominal_i),
   .deexcited_i(deexcited_i), .drive_en_o(drive_en_o),
   .pwm_pad_en_o(pwm_pad_en_o), .excite_en_o(excite_en_o),
   .fast_loop_on_handler_o(fast_loop_on_handler_o),
   .fast_loop_off_handler_o(fast_loop_off_handler_o),
   .sense_corr_start_o(sense_corr_start_o),
   .speed_zero_o(speed_zero_o), .go_rotate_flag_o(go_rotate_flag_o),
   .go_flux_decay_flag_o(go_flux_decay_flag_o),
   .speed_valid_o(speed_valid_o));

// ==== mdss_plant.sv ====
`timescale 1ns/100ps
module mdss_plant (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // test control
   input  wire logic [7:0] dly_i,
   input  wire logic       enc_run_i,
   input  wire logic       enc_dir_i,
   // requests from the block
   input  wire logic       sense_corr_start_i,
   input  wire logic       mains_detect_start_i,
   input  wire logic       excite_en_i,
   input  wire logic       speed_zero_i,
   input  wire logic       deexcite_i,
   // answers to the block
   output logic            sense_corr_done_o,
   output logic            mains_done_o,
   output logic            flux_nominal_o,
   output logic            zero_speed_o,
   output logic            deexcited_o,
   output logic            eos_o,
   output logic            enc_a_o,
   output logic            enc_b_o,
   output int              net_edges_o
);
   logic [7:0] sc_q, md_q, fx_q, zs_q, dx_q;
   logic [3:0] eos_q;
   logic [1:0] ph_q, div_q;

   function automatic logic [7:0] up(input logic [7:0] c);
      return (c < dly_i) ? c + 8'h01 : c;
   endfunction

   assign sense_corr_done_o = (sc_q == dly_i);
   assign mains_done_o      = (md_q == dly_i);
   assign flux_nominal_o    = (fx_q == dly_i);
   assign zero_speed_o      = (zs_q == dly_i);
   assign deexcited_o       = (dx_q == dly_i);
   assign eos_o             = (eos_q == 4'hF);
   assign enc_a_o           = ph_q[0] ^ ph_q[1];
   assign enc_b_o           = ph_q[1];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {sc_q, md_q, fx_q, zs_q, dx_q, eos_q, ph_q, div_q} <= '0;
         net_edges_o <= 0;
      end else begin
         sc_q  <= sense_corr_start_i ? 8'h01 : (sc_q != 8'h00 ? up(sc_q) : sc_q);
         md_q  <= mains_detect_start_i ? 8'h01 : sense_corr_start_i ? 8'h00
                  : (md_q != 8'h00 ? up(md_q) : md_q);
         fx_q  <= excite_en_i ? up(fx_q) : 8'h00;
         zs_q  <= speed_zero_i ? up(zs_q) : 8'h00;
         dx_q  <= deexcite_i ? up(dx_q) : 8'h00;
         eos_q <= eos_q + 4'h1;
         if (enc_run_i) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
               ph_q        <= enc_dir_i ? ph_q + 2'h1 : ph_q - 2'h1;
               net_edges_o <= enc_dir_i ? net_edges_o + 1 : net_edges_o - 1;
            end
         end
      end
   end
endmodule // mdss_plant

// ==== test_motor_drive_supervisor_speed.sv ====
`timescale 1ns/100ps
module test_motor_drive_supervisor_speed;
   import mdss_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00, dly = 8'h03;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o, run_sw_i = 1'b1, enc_run = 1'b0, enc_dir = 1'b1;
   logic [4:0]  fault_i = 5'h00, f;
   logic        ea, eb, scd, mdn, fxn, zsp, dxd, eos, drv, pwm, onh, offh;
   logic        scs, mds, exc, scmd, szr, dex, rot, dec, rmt, sval;
   mdss_word_t  speed, pos;
   int          net, n_mismatch = 0, cmp_count = 0;
   logic [31:0] exp_q[$];

   always #2 clk_i = ~clk_i;

   mdss_top #(.CALC_CYC(2000)) mdss_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_sw_i(run_sw_i),
      .enc_a_i(ea), .enc_b_i(eb), .fault_i(fault_i), .sense_corr_done_i(scd),
      .mains_done_i(mdn), .mains_ok_i(1'b1), .flux_nominal_i(fxn),
      .zero_speed_i(zsp), .deexcited_i(dxd), .eos_i(eos), .drive_en_o(drv),
      .pwm_pad_en_o(pwm), .fast_loop_on_handler_o(onh),
      .fast_loop_off_handler_o(offh), .sense_corr_start_o(scs),
      .mains_detect_start_o(mds), .excite_en_o(exc), .speed_cmd_en_o(scmd),
      .speed_zero_o(szr), .deexcite_o(dex), .go_rotate_flag_o(rot),
      .go_flux_decay_flag_o(dec), .remote_host_mode_o(rmt), .speed_o(speed),
      .speed_valid_o(sval), .position_o(pos));

   mdss_plant mdss_plant_inst (.clk_i(clk_i), .rst_i(rst_i), .dly_i(dly),
      .enc_run_i(enc_run), .enc_dir_i(enc_dir), .sense_corr_start_i(scs),
      .mains_detect_start_i(mds), .excite_en_i(exc), .speed_zero_i(szr),
      .deexcite_i(dex), .sense_corr_done_o(scd), .mains_done_o(mdn),
      .flux_nominal_o(fxn), .zero_speed_o(zsp), .deexcited_o(dxd),
      .eos_o(eos), .enc_a_o(ea), .enc_b_o(eb), .net_edges_o(net));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic hang();
      n_mismatch++;
      final_report();
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      if (n >= 40) hang();
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      wb(1'b0, a, 32'h0);
   endtask

   function automatic logic [31:0] st(input mdss_state_t s, input logic m,
                                      input logic [1:0] lk, input logic [4:0] fl);
      return {19'h0, fl, lk, 1'b0, m, s};
   endfunction

   function automatic logic sel(input int k);
      case (k)
         0: return offh;
         1: return rot;
         2: return dec;
         default: return sval;
      endcase
   endfunction

   task automatic wait_on(input int k);
      int n;
      n = 0;
      while (sel(k) !== 1'b1) begin
         @(posedge clk_i);
         n++;
         if (n > 5000) hang();
      end
      @(posedge clk_i);
   endtask

   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask

   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (exp_q.size() == 0) hang();
         else check(wb_dat_o, exp_q.pop_front());
      end
   end

   initial begin
      repeat (100000) @(posedge clk_i);
      hang();
   end

   initial begin
      void'($urandom(32'hCC0FE774));
      do_reset();
      repeat (40) @(posedge clk_i);
      rd(8'h04, st(MDSS_INIT_OPMODE, 1'b0, 2'b00, 5'h00) | 32'h20);
      check(drv, 1'b0);
      run_sw_i <= 1'b0;
      wait_on(0);
      rd(8'h04, st(MDSS_STOP, 1'b0, 2'b00, 5'h00));
      $display("init test done");
      dly <= 8'd60;
      run_sw_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      check({drv, pwm, exc, rot}, 4'hE);
      run_sw_i <= 1'b0;
      wait_on(2);
      wait_on(0);
      rd(8'h04, st(MDSS_STOP, 1'b0, 2'b00, 5'h00));
      $display("early stop test done");
      dly <= 8'd2 + 8'($urandom % 6);
      wb(1'b1, 8'h00, 32'h10);
      repeat (4) @(posedge clk_i);
      wait_on(0);
      rd(8'h04, st(MDSS_STOP, 1'b1, 2'b00, 5'h00));
      check(rmt, 1'b1);
      run_sw_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      wb(1'b1, 8'h00, 32'h11);
      check(drv, 1'b1);
      wait_on(1);
      check(scmd, 1'b1);
      wb(1'b1, 8'h00, 32'h12);
      run_sw_i <= 1'b0;
      wait_on(2);
      check(szr, 1'b1);
      wait_on(0);
      rd(8'h04, st(MDSS_STOP, 1'b1, 2'b00, 5'h00));
      $display("remote run test done");
      f = 5'h04 << ($urandom % 3);
      fault_i <= f;
      repeat (3) @(posedge clk_i);
      rd(8'h04, st(MDSS_FAULT, 1'b1, 2'b00, f));
      wb(1'b1, 8'h00, 32'h18);
      fault_i <= 5'h00;
      wb(1'b1, 8'h00, 32'h11);
      rd(8'h04, st(MDSS_FAULT, 1'b1, 2'b00, 5'h00));
      wb(1'b1, 8'h00, 32'h18);
      wait_on(0);
      rd(8'h04, st(MDSS_STOP, 1'b1, 2'b00, 5'h00));
      fault_i <= 5'h02;
      repeat (2) @(posedge clk_i);
      fault_i <= 5'h00;
      wb(1'b1, 8'h00, 32'h18);
      repeat (4) @(posedge clk_i);
      rd(8'h04, st(MDSS_FAULT, 1'b1, 2'b10, 5'h00));
      do_reset();
      wait_on(0);
      rd(8'h04, st(MDSS_STOP, 1'b0, 2'b00, 5'h00));
      $display("fault test done");
      enc_run <= 1'b1;
      repeat (2) wait_on(3);
      rd(8'h08, 32'h7FFF);
      enc_dir <= 1'b0;
      repeat (3) wait_on(3);
      wb(1'b1, 8'h08, 32'h1234);
      rd(8'h08, 32'h8001);
      enc_run <= 1'b0;
      repeat (10) @(posedge clk_i);
      check({16'h0, pos}, net[15:0]);
      rd(8'h0C, {16'h0, net[15:0]});
      rd(8'h10, 32'h0);
      $display("speed test done");
      final_report();
   end
endmodule // test_motor_drive_supervisor_speed
